// ---- rtl/dbgcpu_consts.svh ----
// constants of the debug port cpu access block: offsets, codes, timing
// assumes inclusion by the port design file, the checker and the bench, by bare name
// Contract
// - bit 7 write starts reset, self-clears
// - control write wakes halted or sleeping cpu
// - operand bytes upper/high/low at 13h-15h
// - short writes use least significant operand bytes
// - command at 16h, streamable after operands
// - command write executes at once
// - reads land in result upper/high/low bytes
// - writes take data from operand bytes
// - codes 00-05 read af, bc, de, hl, ix, iy
// - codes 80-85 write af, bc, de, hl, ix, iy
// - codes 06/86 pick stack pointer by mode
// - codes 07/87 read and write program counter
// - code 08 sets, 09 clears long mode
// - code 0a swaps primary and alternate sets
// - memory read at pc, then pc increments
// - code 8b writes memory at pc, increments
// - debug address advances after each byte
`ifndef DBGCPU_CONSTS_SVH
`define DBGCPU_CONSTS_SVH

// debug register write addresses
`define DBGCPU_ADDR_MASTER_CTL 8'h11
`define DBGCPU_ADDR_WR_UPPER 8'h13
`define DBGCPU_ADDR_WR_HIGH 8'h14
`define DBGCPU_ADDR_WR_LOW 8'h15
`define DBGCPU_ADDR_COMMAND 8'h16

// master control fields and reset value
`define DBGCPU_MCTL_RESET_BIT 7
`define DBGCPU_MCTL_RESET_VAL 8'h00

// command codes
`define DBGCPU_CMD_RD_AF 8'h00
`define DBGCPU_CMD_RD_BC 8'h01
`define DBGCPU_CMD_RD_DE 8'h02
`define DBGCPU_CMD_RD_HL 8'h03
`define DBGCPU_CMD_RD_IX 8'h04
`define DBGCPU_CMD_RD_IY 8'h05
`define DBGCPU_CMD_RD_SP 8'h06
`define DBGCPU_CMD_RD_PC 8'h07
`define DBGCPU_CMD_SET_ADL 8'h08
`define DBGCPU_CMD_CLR_ADL 8'h09
`define DBGCPU_CMD_EXCHANGE 8'h0A
`define DBGCPU_CMD_RD_MEM 8'h0B
`define DBGCPU_CMD_WR_AF 8'h80
`define DBGCPU_CMD_WR_BC 8'h81
`define DBGCPU_CMD_WR_DE 8'h82
`define DBGCPU_CMD_WR_HL 8'h83
`define DBGCPU_CMD_WR_IX 8'h84
`define DBGCPU_CMD_WR_IY 8'h85
`define DBGCPU_CMD_WR_SP 8'h86
`define DBGCPU_CMD_WR_PC 8'h87
`define DBGCPU_CMD_WR_MEM 8'h8B

// timing
`define DBGCPU_CLK_NS 40
`define DBGCPU_RESET_NS 2000
`define DBGCPU_RESET_CYC \
    ((`DBGCPU_RESET_NS + `DBGCPU_CLK_NS - 1) / `DBGCPU_CLK_NS)

`endif

// ---- rtl/dbgcpu_pkg.sv ----
// types of the debug port cpu access block
// needs nothing from dbgcpu_consts.svh and does not include it
package dbgcpu_pkg;

    // operation asked of the cpu core
    typedef enum logic [2:0] {
        DBGCPU_OP_RD,
        DBGCPU_OP_WR,
        DBGCPU_OP_ADL_SET,
        DBGCPU_OP_ADL_CLR,
        DBGCPU_OP_EXCHANGE,
        DBGCPU_OP_MEM_RD,
        DBGCPU_OP_MEM_WR
    } dbgcpu_op_t;

    // cpu register triple selected
    typedef enum logic [3:0] {
        DBGCPU_R_AF,
        DBGCPU_R_BC,
        DBGCPU_R_DE,
        DBGCPU_R_HL,
        DBGCPU_R_IX,
        DBGCPU_R_IY,
        DBGCPU_R_SPL,
        DBGCPU_R_SPS,
        DBGCPU_R_PC
    } dbgcpu_reg_t;

    // one request to the cpu core
    typedef struct packed {
        dbgcpu_op_t op;
        dbgcpu_reg_t sel;
        logic [23:0] addr;
        logic [23:0] data;
    } dbgcpu_cmd_t;

    // one byte written by the master, with its debug address
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } dbgcpu_wbyte_t;

endpackage

// ---- rtl/dbgcpu_sync2.sv ----
// two flip-flop level synchroniser
// assumes a level that changes slower than the receiving clock
`timescale 1ns/1ps
`default_nettype none
module dbgcpu_sync2 (
    // receiving clock domain
    input wire logic clk_i,
    input wire logic rst_n_i,
    // level in and synchronised level out
    input wire logic d_i,
    output logic q_o
);
    logic meta;

    // first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/dbgcpu_port.sv ----
// debug port cpu access layer: byte writes from the serial link domain,
// command execution against the cpu core on the system clock
// assumes the cpu core answers each request with a one-cycle ack
`timescale 1ns/1ps
`default_nettype none
`include "dbgcpu_consts.svh"
module dbgcpu_port
    import dbgcpu_pkg::*;
(
    // system clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // link side, on the link clock
    input wire logic link_clk_i,
    input wire logic lnk_start_i,
    input wire logic lnk_byte_i,
    input wire logic [7:0] lnk_data_i,
    output logic lnk_busy_o,
    output logic [23:0] lnk_rd_result_o,
    // cpu core request port
    output logic cpu_req_o,
    output dbgcpu_cmd_t cpu_cmd_o,
    input wire logic cpu_ack_i,
    input wire logic [23:0] cpu_rdata_i,
    input wire logic cpu_adl_i,
    // device control
    output logic debug_reset_request_o,
    output logic wake_o
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CPU,
        ST_PC_RD,
        ST_AF_RD,
        ST_MEM,
        ST_PC_WR,
        ST_DONE
    } dbgcpu_state_t;

    // link domain state
    logic [7:0] lnk_addr;
    dbgcpu_wbyte_t hold;
    logic req_tgl;
    logic ack_sync;
    logic ack_seen;

    // system domain state
    logic req_sync;
    logic req_seen;
    logic ack_tgl;
    dbgcpu_state_t state;
    logic [23:0] wr_operand;
    logic [23:0] read_result;
    logic [23:0] pc_copy;
    logic [7:0] memory_base_byte_copy;
    logic mem_is_read;
    logic reset_req;
    logic [7:0] reset_cnt;

    logic new_byte;
    logic ack_edge;
    logic mctl_reset_wr;

    assign ack_edge = ack_sync ^ ack_seen;
    assign new_byte = (req_sync ^ req_seen) && (state == ST_IDLE);
    assign mctl_reset_wr = new_byte
        && (hold.addr == `DBGCPU_ADDR_MASTER_CTL)
        && hold.data[`DBGCPU_MCTL_RESET_BIT];

    // crossings: request toggle to system, ack toggle back to link
    dbgcpu_sync2 u_req_sync (
        .clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(req_tgl),
        .q_o(req_sync)
    );

    dbgcpu_sync2 u_ack_sync (
        .clk_i(link_clk_i),
        .rst_n_i(rst_n_i),
        .d_i(ack_tgl),
        .q_o(ack_sync)
    );

    // debug address: loaded at frame start, advances per byte
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lnk_addr <= 8'h00;
        end else if (lnk_start_i) begin
            lnk_addr <= lnk_data_i;
        end else if (lnk_byte_i) begin
            lnk_addr <= lnk_addr + 8'h01;
        end
    end

    // byte capture; held still until the system side answers
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold <= '0;
            req_tgl <= 1'b0;
        end else if (lnk_byte_i && !lnk_start_i && !lnk_busy_o) begin
            hold.addr <= lnk_addr;
            hold.data <= lnk_data_i;
            req_tgl <= ~req_tgl;
        end
    end

    // busy from capture until the ack comes back
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lnk_busy_o <= 1'b0;
            ack_seen <= 1'b0;
        end else if (ack_edge) begin
            lnk_busy_o <= 1'b0;
            ack_seen <= ack_sync;
        end else if (lnk_byte_i && !lnk_start_i) begin
            lnk_busy_o <= 1'b1;
        end
    end

    // read data copied once settled
    always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lnk_rd_result_o <= 24'h00_0000;
        end else if (ack_edge) begin
            lnk_rd_result_o <= read_result;
        end
    end

    // operand bytes, upper byte most significant
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_operand <= 24'h00_0000;
        end else if (new_byte) begin
            case (hold.addr)
                `DBGCPU_ADDR_WR_UPPER: wr_operand[23:16] <= hold.data;
                `DBGCPU_ADDR_WR_HIGH: wr_operand[15:8] <= hold.data;
                `DBGCPU_ADDR_WR_LOW: wr_operand[7:0] <= hold.data;
                default: ;
            endcase
        end
    end

    // forced device reset; a new request wins over the self-clear
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_req <= 1'b0;
            reset_cnt <= 8'h00;
        end else if (mctl_reset_wr) begin
            reset_req <= 1'b1;
            reset_cnt <= 8'(`DBGCPU_RESET_CYC - 1);
        end else if (reset_req) begin
            if (reset_cnt == 8'h00) begin
                reset_req <= 1'b0;
            end else begin
                reset_cnt <= reset_cnt - 8'h01;
            end
        end
    end

    // reset and wake outputs straight from flops
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            debug_reset_request_o <= 1'b0;
            wake_o <= 1'b0;
        end else begin
            debug_reset_request_o <= reset_req;
            // any control write wakes the core from halt or sleep
            wake_o <= new_byte
                && (hold.addr == `DBGCPU_ADDR_MASTER_CTL);
        end
    end

    // command engine: one cpu request at a time, ack back to link
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= ST_IDLE;
            req_seen <= 1'b0;
            ack_tgl <= 1'b0;
            cpu_req_o <= 1'b0;
            cpu_cmd_o <= '0;
            read_result <= 24'h00_0000;
            pc_copy <= 24'h00_0000;
            memory_base_byte_copy <= 8'h00;
            mem_is_read <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (new_byte) begin
                        req_seen <= req_sync;
                        state <= ST_DONE;
                        if (hold.addr == `DBGCPU_ADDR_COMMAND) begin
                            cpu_cmd_o.addr <= 24'h00_0000;
                            cpu_cmd_o.data <= wr_operand;
                            cpu_cmd_o.sel <= DBGCPU_R_AF;
                            cpu_cmd_o.op <= DBGCPU_OP_RD;
                            cpu_req_o <= 1'b1;
                            state <= ST_CPU;
                            // decode runs on the write itself
                            case (hold.data)
                                `DBGCPU_CMD_RD_AF,
                                `DBGCPU_CMD_RD_BC,
                                `DBGCPU_CMD_RD_DE,
                                `DBGCPU_CMD_RD_HL,
                                `DBGCPU_CMD_RD_IX,
                                `DBGCPU_CMD_RD_IY: begin
                                    cpu_cmd_o.sel <=
                                        dbgcpu_reg_t'(hold.data[3:0]);
                                end
                                `DBGCPU_CMD_WR_AF,
                                `DBGCPU_CMD_WR_BC,
                                `DBGCPU_CMD_WR_DE,
                                `DBGCPU_CMD_WR_HL,
                                `DBGCPU_CMD_WR_IX,
                                `DBGCPU_CMD_WR_IY: begin
                                    cpu_cmd_o.op <= DBGCPU_OP_WR;
                                    cpu_cmd_o.sel <=
                                        dbgcpu_reg_t'(hold.data[3:0]);
                                end
                                `DBGCPU_CMD_RD_SP,
                                `DBGCPU_CMD_WR_SP: begin
                                    if (hold.data[7]) begin
                                        cpu_cmd_o.op <= DBGCPU_OP_WR;
                                    end
                                    cpu_cmd_o.sel <= cpu_adl_i ?
                                        DBGCPU_R_SPL : DBGCPU_R_SPS;
                                end
                                `DBGCPU_CMD_RD_PC,
                                `DBGCPU_CMD_WR_PC: begin
                                    if (hold.data[7]) begin
                                        cpu_cmd_o.op <= DBGCPU_OP_WR;
                                    end
                                    cpu_cmd_o.sel <= DBGCPU_R_PC;
                                end
                                `DBGCPU_CMD_SET_ADL: begin
                                    cpu_cmd_o.op <= DBGCPU_OP_ADL_SET;
                                end
                                `DBGCPU_CMD_CLR_ADL: begin
                                    cpu_cmd_o.op <= DBGCPU_OP_ADL_CLR;
                                end
                                `DBGCPU_CMD_EXCHANGE: begin
                                    // the only path to the alternate set
                                    cpu_cmd_o.op <= DBGCPU_OP_EXCHANGE;
                                end
                                `DBGCPU_CMD_RD_MEM,
                                `DBGCPU_CMD_WR_MEM: begin
                                    // pc fetched first to form the address
                                    mem_is_read <= ~hold.data[7];
                                    cpu_cmd_o.sel <= DBGCPU_R_PC;
                                    state <= ST_PC_RD;
                                end
                                default: begin
                                    cpu_req_o <= 1'b0;
                                    state <= ST_DONE;
                                end
                            endcase
                        end
                    end
                end
                ST_CPU: begin
                    if (cpu_ack_i) begin
                        cpu_req_o <= 1'b0;
                        if (cpu_cmd_o.op == DBGCPU_OP_RD) begin
                            read_result <= cpu_rdata_i;
                        end
                        state <= ST_DONE;
                    end
                end
                ST_PC_RD: begin
                    if (cpu_ack_i) begin
                        pc_copy <= cpu_rdata_i;
                        cpu_cmd_o.sel <= DBGCPU_R_AF;
                        // short mode needs the base byte for the address
                        state <= cpu_adl_i ? ST_MEM : ST_AF_RD;
                        cpu_req_o <= 1'b0;
                    end
                end
                ST_AF_RD: begin
                    // request drops a cycle between steps
                    if (!cpu_req_o) begin
                        cpu_req_o <= 1'b1;
                    end else if (cpu_ack_i) begin
                        cpu_req_o <= 1'b0;
                        memory_base_byte_copy <= cpu_rdata_i[23:16];
                        state <= ST_MEM;
                    end
                end
                ST_MEM: begin
                    if (!cpu_req_o) begin
                        cpu_cmd_o.op <= mem_is_read ?
                            DBGCPU_OP_MEM_RD : DBGCPU_OP_MEM_WR;
                        cpu_cmd_o.addr <= cpu_adl_i ? pc_copy :
                            {memory_base_byte_copy, pc_copy[15:0]};
                        // only the low operand byte goes to memory
                        cpu_cmd_o.data <= {16'h0000, wr_operand[7:0]};
                        cpu_req_o <= 1'b1;
                    end else if (cpu_ack_i) begin
                        if (mem_is_read) begin
                            read_result <=
                                {16'h0000, cpu_rdata_i[7:0]};
                        end
                        cpu_cmd_o.op <= DBGCPU_OP_WR;
                        cpu_cmd_o.sel <= DBGCPU_R_PC;
                        cpu_cmd_o.data <= cpu_adl_i ? pc_copy + 24'h00_0001 :
                            {pc_copy[23:16],
                             pc_copy[15:0] + 16'h0001};
                        cpu_req_o <= 1'b0;
                        state <= ST_PC_WR;
                    end
                end
                ST_PC_WR: begin
                    if (!cpu_req_o) begin
                        cpu_req_o <= 1'b1;
                    end else if (cpu_ack_i) begin
                        cpu_req_o <= 1'b0;
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    ack_tgl <= ~ack_tgl;
                    state <= ST_IDLE;
                end
                default: begin
                    cpu_req_o <= 1'b0;
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- bench/dbgcpu_port_sva.sv ----
// checker of the debug port cpu access block
// assumes a bind onto dbgcpu_port; one reset for both clocks
`timescale 1ns/1ps
`default_nettype none
`include "dbgcpu_consts.svh"
module dbgcpu_port_sva
    import dbgcpu_pkg::*;
(
    // clocks and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic link_clk_i,
    // link side
    input wire logic lnk_start_i,
    input wire logic lnk_byte_i,
    input wire logic lnk_busy_o,
    input wire logic [23:0] lnk_rd_result_o,
    // cpu side and device control
    input wire logic cpu_req_o,
    input wire dbgcpu_cmd_t cpu_cmd_o,
    input wire logic cpu_ack_i,
    input wire logic cpu_adl_i,
    input wire logic debug_reset_request_o,
    input wire logic wake_o
);
    localparam int RST_CYC = `DBGCPU_RESET_CYC;
    int hold_cnt;

    // cycles the reset request has stood
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_cnt <= 0;
        end else begin
            hold_cnt <= debug_reset_request_o ? hold_cnt + 1 : 0;
        end
    end

    a_cmd_held_stable: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cpu_req_o && !cpu_ack_i |=> cpu_req_o && $stable(cpu_cmd_o))
        else $error("request changed before ack");
    a_req_ends_ack: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cpu_req_o && cpu_ack_i |=> !cpu_req_o)
        else $error("request held past ack");
    a_reset_len_exact: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $fell(debug_reset_request_o) |-> hold_cnt == RST_CYC)
        else $error("reset request length wrong");
    a_reset_after_wake: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(debug_reset_request_o) |->
            $past(wake_o) || $past(wake_o, 2) || $past(wake_o, 3))
        else $error("reset without control write");
    a_wake_one_cycle: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        wake_o |=> !wake_o)
        else $error("wake pulse too long");
    a_byte_sets_busy: assert property (
        @(posedge link_clk_i) disable iff (!rst_n_i)
        lnk_byte_i && !lnk_start_i && !lnk_busy_o |=> lnk_busy_o)
        else $error("byte did not raise busy");
    a_busy_ends_soon: assert property (
        @(posedge link_clk_i) disable iff (!rst_n_i)
        $rose(lnk_busy_o) |-> ##[1:60] !lnk_busy_o)
        else $error("byte never completed");
    a_result_idle_hold: assert property (
        @(posedge link_clk_i) disable iff (!rst_n_i)
        !lnk_busy_o |=> $stable(lnk_rd_result_o))
        else $error("result changed while idle");
    a_sp_by_mode: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cpu_req_o && cpu_cmd_o.op inside {DBGCPU_OP_RD, DBGCPU_OP_WR} &&
        cpu_cmd_o.sel inside {DBGCPU_R_SPL, DBGCPU_R_SPS} |->
            (cpu_cmd_o.sel == DBGCPU_R_SPL) == cpu_adl_i)
        else $error("stack pointer ignores mode");
    a_mem_then_pc: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        cpu_req_o && cpu_ack_i &&
        cpu_cmd_o.op inside {DBGCPU_OP_MEM_RD, DBGCPU_OP_MEM_WR} |->
            ##[1:8] cpu_req_o && cpu_cmd_o.op == DBGCPU_OP_WR &&
            cpu_cmd_o.sel == DBGCPU_R_PC)
        else $error("no pc update after memory");
endmodule

bind dbgcpu_port dbgcpu_port_sva i_sva (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .link_clk_i(link_clk_i),
    .lnk_start_i(lnk_start_i), .lnk_byte_i(lnk_byte_i),
    .lnk_busy_o(lnk_busy_o), .lnk_rd_result_o(lnk_rd_result_o),
    .cpu_req_o(cpu_req_o), .cpu_cmd_o(cpu_cmd_o), .cpu_ack_i(cpu_ack_i),
    .cpu_adl_i(cpu_adl_i), .wake_o(wake_o),
    .debug_reset_request_o(debug_reset_request_o)
);
`default_nettype wire

// ---- bench/dbgcpu_core_model.sv ----
// cpu core model on the block's request port
// assumes requests held until ack; memory decoded on address bits 7:0
`timescale 1ns/1ps
`default_nettype none
module dbgcpu_core_model
    import dbgcpu_pkg::*;
(
    // system clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // request port of the block
    input wire logic cpu_req_i,
    input wire dbgcpu_cmd_t cpu_cmd_i,
    output logic cpu_ack_o,
    output logic [23:0] cpu_rdata_o,
    output logic cpu_adl_o
);
    logic [23:0] regs [0:8];
    logic [23:0] alt [0:3];
    logic [7:0] mem [0:255];
    logic [23:0] last_addr;
    logic [1:0] wait_cnt;
    logic slow;

    // acks alternate prompt and two cycles late
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cpu_ack_o <= 1'b0;
            wait_cnt <= 2'h0;
            slow <= 1'b0;
            cpu_adl_o <= 1'b0;
            cpu_rdata_o <= 24'h00_0000;
            for (int i = 0; i < 9; i++) regs[i] <= 24'h00_0000;
            for (int i = 0; i < 4; i++) alt[i] <= 24'hA0_0000 + 24'(i);
        end else if (cpu_ack_o || !cpu_req_i) begin
            cpu_ack_o <= 1'b0;
            wait_cnt <= 2'h0;
            cpu_rdata_o <= ~cpu_rdata_o; // no stale data
        end else if (wait_cnt != {slow, 1'b0}) begin
            wait_cnt <= wait_cnt + 2'h1;
        end else begin
            cpu_ack_o <= 1'b1;
            slow <= !slow;
            case (cpu_cmd_i.op)
                DBGCPU_OP_RD: cpu_rdata_o <= regs[cpu_cmd_i.sel];
                DBGCPU_OP_WR: regs[cpu_cmd_i.sel] <= cpu_cmd_i.data;
                DBGCPU_OP_ADL_SET: cpu_adl_o <= 1'b1;
                DBGCPU_OP_ADL_CLR: cpu_adl_o <= 1'b0;
                DBGCPU_OP_EXCHANGE: begin
                    for (int i = 0; i < 4; i++) begin
                        regs[i] <= alt[i];
                        alt[i] <= regs[i];
                    end
                end
                DBGCPU_OP_MEM_RD: begin
                    cpu_rdata_o <= {16'h0000, mem[cpu_cmd_i.addr[7:0]]};
                    last_addr <= cpu_cmd_i.addr;
                end
                DBGCPU_OP_MEM_WR: begin
                    mem[cpu_cmd_i.addr[7:0]] <= cpu_cmd_i.data[7:0];
                    last_addr <= cpu_cmd_i.addr;
                end
                default: ;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- bench/debug_port_cpu_access_bench.sv ----
// bench: link byte writes drive commands into a core model
// assumes dbgcpu_port, dbgcpu_core_model and the bound checker
`timescale 1ns/1ps
`default_nettype none
`include "dbgcpu_consts.svh"
`define CHK(got, exp) check(24'(got), 24'(exp))
module debug_port_cpu_access_bench
    import dbgcpu_pkg::*;
;
    logic sys_clk, link_clk, rst_n, lnk_start, lnk_byte;
    logic [7:0] lnk_data;
    logic lnk_busy, cpu_req, cpu_ack, cpu_adl, rst_req, wake;
    logic [23:0] rd_result, cpu_rdata, v;
    dbgcpu_cmd_t cpu_cmd;
    int error_cnt = 0, n_checks = 0, req_cnt = 0, wake_cnt = 0, rst_cyc = 0;
    int n, w;

    dbgcpu_port i_dut (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .link_clk_i(link_clk), .lnk_start_i(lnk_start),
        .lnk_byte_i(lnk_byte), .lnk_data_i(lnk_data),
        .lnk_busy_o(lnk_busy), .lnk_rd_result_o(rd_result),
        .cpu_req_o(cpu_req), .cpu_cmd_o(cpu_cmd), .cpu_ack_i(cpu_ack),
        .cpu_rdata_i(cpu_rdata), .cpu_adl_i(cpu_adl),
        .debug_reset_request_o(rst_req), .wake_o(wake));
    dbgcpu_core_model i_core (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
        .cpu_req_i(cpu_req), .cpu_cmd_i(cpu_cmd), .cpu_ack_o(cpu_ack),
        .cpu_rdata_o(cpu_rdata), .cpu_adl_o(cpu_adl));

    // clocks of unrelated phase
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #80 link_clk = ~link_clk;
    end

    // event counters
    always @(posedge sys_clk) begin
        if (cpu_req && cpu_ack) req_cnt <= req_cnt + 1;
        if (wake) wake_cnt <= wake_cnt + 1;
        if (rst_req) rst_cyc <= rst_cyc + 1;
    end

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic send_start(input logic [7:0] a);
        @(posedge link_clk);
        lnk_start <= 1'b1;
        lnk_data <= a;
        @(posedge link_clk);
        lnk_start <= 1'b0;
    endtask

    // one byte, then wait out busy
    task automatic send_byte(input logic [7:0] d);
        int k = 0;
        @(posedge link_clk);
        lnk_byte <= 1'b1;
        lnk_data <= d;
        @(posedge link_clk);
        lnk_byte <= 1'b0;
        do begin
            @(posedge link_clk);
            k++;
        end while (lnk_busy !== 1'b0 && k < 80);
        if (k == 80) begin
            `CHK(lnk_busy, 0);
            complete_run();
        end
    endtask

    // operands then command in one stream
    task automatic run_cmd(input logic [23:0] op, input logic [7:0] code);
        send_start(`DBGCPU_ADDR_WR_UPPER);
        for (int i = 2; i >= 0; i--) send_byte(op[8*i +: 8]);
        send_byte(code);
    endtask

    task automatic issue(input logic [7:0] code);
        send_start(`DBGCPU_ADDR_COMMAND);
        send_byte(code);
    endtask

    initial begin
        rst_n = 1'b0;
        lnk_start = 1'b0;
        lnk_byte = 1'b0;
        lnk_data = 8'h00;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge link_clk);
        `CHK(rst_req, 0);
        `CHK(cpu_req, 0);
        $display("test reset done");
        for (int k = 0; k < 6; k++) begin
            v = {8'h30 + 8'(k), 8'h50 + 8'(k), 8'h70 + 8'(k)};
            run_cmd(v, 8'h80 + 8'(k));
            issue(8'(k));
            `CHK(rd_result, v);
        end
        $display("test triples done");
        issue(8'h0A);
        issue(8'h01);
        `CHK(rd_result, 24'hA0_0001);
        issue(8'h00);
        `CHK(rd_result, 24'hA0_0000);
        issue(8'h0A);
        issue(8'h01);
        `CHK(rd_result, 24'h31_5171);
        $display("test exchange done");
        issue(8'h08);
        `CHK(cpu_adl, 1);
        run_cmd(24'h11_2233, 8'h86);
        issue(8'h09);
        `CHK(cpu_adl, 0);
        run_cmd(24'h00_4455, 8'h86);
        issue(8'h06);
        `CHK(rd_result, 24'h00_4455);
        issue(8'h08);
        issue(8'h06);
        `CHK(rd_result, 24'h11_2233);
        $display("test stack done");
        run_cmd(24'h00_0040, 8'h87);
        issue(8'h07);
        `CHK(rd_result, 24'h00_0040);
        run_cmd(24'h77_665A, 8'h8B);
        `CHK(i_core.mem[8'h40], 8'h5A);
        `CHK(i_core.last_addr, 24'h00_0040);
        issue(8'h07);
        `CHK(rd_result, 24'h00_0041);
        run_cmd(24'h00_0040, 8'h87);
        issue(8'h0B);
        `CHK(rd_result, 24'h00_005A);
        issue(8'h07);
        `CHK(rd_result, 24'h00_0041);
        issue(8'h09);
        run_cmd(24'h12_0000, 8'h80);
        run_cmd(24'h34_FFFF, 8'h87);
        run_cmd(24'h00_00C3, 8'h8B);
        `CHK(i_core.last_addr, 24'h12_FFFF);
        `CHK(i_core.mem[8'hFF], 8'hC3);
        issue(8'h07);
        `CHK(rd_result, 24'h34_0000);
        $display("test memory done");
        w = req_cnt;
        for (int k = 0; k < 3; k++) begin
            run_cmd(24'h99_9999, 8'h88 + 8'(k));
        end
        `CHK(req_cnt, w);
        issue(8'h01);
        `CHK(rd_result, 24'h31_5171);
        $display("test reserved done");
        w = wake_cnt;
        send_start(`DBGCPU_ADDR_MASTER_CTL);
        send_byte(8'h00);
        `CHK(wake_cnt, w + 1);
        `CHK(rst_cyc, 0);
        send_start(`DBGCPU_ADDR_MASTER_CTL);
        send_byte(8'h80);
        n = 0;
        while (!(rst_cyc > 0 && rst_req === 1'b0) && n < 300) begin
            @(posedge sys_clk);
            n++;
        end
        `CHK(rst_cyc, `DBGCPU_RESET_CYC);
        `CHK(wake_cnt, w + 2);
        $display("test control done");
        complete_run();
    end
endmodule
`default_nettype wire
